// ---- pkg/sym_loop_pkg.sv ----
// Package of register destinations, field layouts and timing for the symbol loop filter
`default_nettype none
package sym_loop_pkg;
	// ------------------------------------------------------------
	// Destination addresses
	// ------------------------------------------------------------
	localparam logic [7:0] DEST_GAIN_ACQ    = 8'h11;    // Acquisition gain set
	localparam logic [7:0] DEST_GAIN_TRK    = 8'h12;    // Track gain set
	localparam logic [7:0] DEST_LAG_INIT    = 8'h13;    // Lag accumulator load strobe
	// ------------------------------------------------------------
	// Gain field layout
	// ------------------------------------------------------------
	localparam int LEAD_MANT_HI = 17;                   // Lead mantissa MSB
	localparam int LEAD_MANT_LO = 14;                   // Lead mantissa LSB
	localparam int LEAD_EXP_HI  = 13;                   // Lead exponent MSB
	localparam int LEAD_EXP_LO  = 9;                    // Lead exponent LSB
	localparam int LAG_MANT_HI  = 8;                    // Lag mantissa MSB
	localparam int LAG_MANT_LO  = 5;                    // Lag mantissa LSB
	localparam int LAG_EXP_HI   = 4;                    // Lag exponent MSB
	localparam int LAG_EXP_LO   = 0;                    // Lag exponent LSB
	localparam int GAIN_W       = 18;                   // Stored gain bits
	localparam logic [17:0] GAIN_RST = 18'h00000;       // Gain reset value
	// ------------------------------------------------------------
	// Datapath sizes and timing
	// ------------------------------------------------------------
	localparam int ACC_W        = 40;                   // Lag accumulator width
	localparam int ACC_FRAC     = 8;                    // Cleared low bits on load
	localparam int ERR_W        = 16;                   // Sampling error width
	localparam int COMPUTE_CLKS = 8;                    // Clocks per compute cycle
	localparam logic [2:0] PHASE_LAST = 3'h7;           // Last phase of a cycle
	localparam int EXP_BIAS     = 32;                   // Exponent offset
endpackage
`default_nettype wire

// ---- hw/gain_shift.sv ----
// Mantissa/exponent scaling of a sampling error into the accumulator format
`timescale 1ns/10ps
`default_nettype none
module gain_shift
(
	input  wire logic signed [15:0] err,   // Signed sampling error
	input  wire logic        [3:0]  mant,  // Fraction bits of 01.xxxx
	input  wire logic        [4:0]  expo,  // Exponent code E
	output logic      signed [39:0] prod   // Scaled term, accumulator scale
);
	// Full product width: error times 5-bit mantissa, left-aligned
	logic signed [21:0] mul;               // err * 1.xxxx in units of 1/16
	logic signed [71:0] wide;              // Product placed above binary point
	logic        [5:0]  rsh;               // Right shift 32-E

	// Mantissa is 1.xxxx so the multiplier is 16 + fraction
	assign mul  = err * $signed({2'b01, mant});
	// Error MSB aligns to NCO word MSB; 8 extra fractional bits kept
	assign wide = {{18{mul[21]}}, mul, 32'h00000000};
	assign rsh  = 6'(sym_loop_pkg::EXP_BIAS) - {1'b0, expo};
	assign prod = 40'((wide >>> rsh) >>> 20);
endmodule // gain_shift
`default_nettype wire

// ---- hw/sym_loop_filter.sv ----
// Symbol loop filter gain registers, lag accumulator and its software load
`timescale 1ns/10ps
`default_nettype none
module sym_loop_filter
(
	input  wire logic               core_clk,     // Device clock
	input  wire logic               nrst,         // Async reset, low
	input  wire logic               wr_strobe,    // One-cycle register write
	input  wire logic        [7:0]  wr_dest,      // Destination address
	input  wire logic        [31:0] wr_data,      // Assembled write word
	input  wire logic        [31:0] holding,      // Four holding bytes
	input  wire logic        [31:0] upper_limit,  // Accumulator upper limit
	input  wire logic        [31:0] lower_limit,  // Accumulator lower limit
	input  wire logic               track_mode,   // 1 = track, 0 = acquisition
	input  wire logic signed [15:0] samp_err,     // Sampling error input
	output logic                    load_done_ff, // Load complete status
	output logic      signed [31:0] nco_out_ff,   // Loop filter output
	output logic                    out_valid_ff, // Output strobe
	output logic      signed [39:0] lag_acc_ff    // Lag accumulator
);
	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	logic [17:0]        gain_acq_ff;     // Acquisition gain set
	logic [17:0]        gain_trk_ff;     // Track gain set
	logic [2:0]         phase_ff;        // Position in compute cycle
	logic               pend_ff;         // Load requested, not yet done
	logic signed [15:0] err_ff;          // Error captured at cycle start
	logic [17:0]        gain_sel;        // Gain set in use
	logic signed [39:0] lead_term;       // Scaled lead error
	logic signed [39:0] lag_term;        // Scaled lag error
	logic signed [40:0] sum;             // Unclamped accumulator sum
	logic signed [40:0] up_ext;          // Upper limit at sum scale
	logic signed [40:0] lo_ext;          // Lower limit at sum scale
	logic signed [39:0] nxt_lag_acc;     // Next accumulator value
	logic signed [40:0] out_sum;         // Lead plus lag
	logic               cyc_start;       // First clock of compute cycle
	logic               init_req;        // Strobe write seen

	assign cyc_start = (phase_ff == 3'h0);
	assign init_req  = wr_strobe && (wr_dest == sym_loop_pkg::DEST_LAG_INIT);

	// ------------------------------------------------------------
	// Gain registers
	// ------------------------------------------------------------
	// Only the 18 defined bits are kept; reserved and unused are dropped
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			gain_acq_ff <= sym_loop_pkg::GAIN_RST;
			gain_trk_ff <= sym_loop_pkg::GAIN_RST;
		end
		else if (wr_strobe && wr_dest == sym_loop_pkg::DEST_GAIN_ACQ)
		begin
			gain_acq_ff <= wr_data[17:0];
		end
		else if (wr_strobe && wr_dest == sym_loop_pkg::DEST_GAIN_TRK)
		begin
			gain_trk_ff <= wr_data[17:0];
		end
	end

	// Mode picks the set
	assign gain_sel = track_mode ? gain_trk_ff : gain_acq_ff;

	// ------------------------------------------------------------
	// Compute cycle sequencer
	// ------------------------------------------------------------
	// Free-running eight clock phase counter
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			phase_ff <= 3'h0;
		else
			phase_ff <= phase_ff + 3'h1;
	end

	// Error sampled once per compute cycle
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			err_ff <= 16'sh0000;
		else if (cyc_start)
			err_ff <= samp_err;
	end

	// ------------------------------------------------------------
	// Gain scaling
	// ------------------------------------------------------------
	gain_shift u_lead
	(
		.err  (err_ff),
		.mant (gain_sel[sym_loop_pkg::LEAD_MANT_HI:sym_loop_pkg::LEAD_MANT_LO]),
		.expo (gain_sel[sym_loop_pkg::LEAD_EXP_HI:sym_loop_pkg::LEAD_EXP_LO]),
		.prod (lead_term)
	);

	gain_shift u_lag
	(
		.err  (err_ff),
		.mant (gain_sel[sym_loop_pkg::LAG_MANT_HI:sym_loop_pkg::LAG_MANT_LO]),
		.expo (gain_sel[sym_loop_pkg::LAG_EXP_HI:sym_loop_pkg::LAG_EXP_LO]),
		.prod (lag_term)
	);

	// ------------------------------------------------------------
	// Lag accumulator
	// ------------------------------------------------------------
	// Sum and clamp against limits placed above the 8 fraction bits
	always_comb
	begin
		sum    = 41'(lag_acc_ff) + 41'(lag_term);
		// A concatenation is unsigned, so sign is applied before widening
		up_ext = 41'($signed({upper_limit, 8'h00}));
		lo_ext = 41'($signed({lower_limit, 8'h00}));
		if (sum > up_ext)
			nxt_lag_acc = {upper_limit, 8'h00};
		else if (sum < lo_ext)
			nxt_lag_acc = {lower_limit, 8'h00};
		else
			nxt_lag_acc = sum[39:0];
	end

	// Load wins over accumulation on the last phase of a compute cycle
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			lag_acc_ff <= 40'sh0000000000;
		else if (phase_ff == sym_loop_pkg::PHASE_LAST)
		begin
			if (pend_ff)
				lag_acc_ff <= {holding, 8'h00};
			else
				lag_acc_ff <= nxt_lag_acc;
		end
	end

	// ------------------------------------------------------------
	// Load request and completion status
	// ------------------------------------------------------------
	// Pending until the load edge; a new strobe on that edge re-arms
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			pend_ff <= 1'b0;
		else if (init_req)
			pend_ff <= 1'b1;
		else if (phase_ff == sym_loop_pkg::PHASE_LAST)
			pend_ff <= 1'b0;
	end

	// Done flag drops on request, rises once the load happened
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			load_done_ff <= 1'b1;
		else if (init_req)
			load_done_ff <= 1'b0;
		else if (pend_ff && phase_ff == sym_loop_pkg::PHASE_LAST)
			load_done_ff <= 1'b1;
	end

	// ------------------------------------------------------------
	// Filter output
	// ------------------------------------------------------------
	assign out_sum = 41'(lead_term) + 41'(lag_acc_ff);

	// Output word is the upper 32 bits of lead plus lag
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			nco_out_ff   <= 32'sh00000000;
			out_valid_ff <= 1'b0;
		end
		else
		begin
			out_valid_ff <= (phase_ff == sym_loop_pkg::PHASE_LAST);
			if (phase_ff == sym_loop_pkg::PHASE_LAST)
				nco_out_ff <= out_sum[39:8];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_load_fills_acc: assert property (@(posedge core_clk) disable iff (!nrst)
		(pend_ff && phase_ff == sym_loop_pkg::PHASE_LAST && !init_req)
		|=> (lag_acc_ff == {$past(holding), 8'h00}))
		else $error("lag accumulator load wrong");
	// A strobe taken on the phase 7 edge waits a whole compute cycle
	a_load_within_cycle: assert property (@(posedge core_clk) disable iff (!nrst)
		init_req |=> ##[0:8] (load_done_ff || init_req))
		else $error("load not done within compute cycle");
	a_done_drops: assert property (@(posedge core_clk) disable iff (!nrst)
		init_req |=> !load_done_ff)
		else $error("done flag did not clear");
	a_eight_clk_cycle: assert property (@(posedge core_clk) disable iff (!nrst)
		out_valid_ff |=> !out_valid_ff [*7] ##1 out_valid_ff)
		else $error("compute cycle not eight clocks");
	a_acc_upper: assert property (@(posedge core_clk) disable iff (!nrst)
		($past(phase_ff) == sym_loop_pkg::PHASE_LAST && !$past(pend_ff)
		&& $past(sum) > $past(up_ext)) |-> lag_acc_ff == {$past(upper_limit), 8'h00})
		else $error("upper clamp failed");
	a_acc_holds: assert property (@(posedge core_clk) disable iff (!nrst)
		(phase_ff != sym_loop_pkg::PHASE_LAST) |=> $stable(lag_acc_ff))
		else $error("accumulator moved mid cycle");
	a_gain_mode: assert property (@(posedge core_clk) disable iff (!nrst)
		track_mode |-> gain_sel == gain_trk_ff)
		else $error("wrong gain set");
	a_trk_gain_write: assert property (@(posedge core_clk) disable iff (!nrst)
		(wr_strobe && wr_dest == sym_loop_pkg::DEST_GAIN_TRK) |=> gain_trk_ff == $past(wr_data[17:0]))
		else $error("track gain write lost");
	a_out_sum: assert property (@(posedge core_clk) disable iff (!nrst)
		out_valid_ff |-> nco_out_ff == $past(out_sum[39:8]))
		else $error("output sum wrong");
endmodule // sym_loop_filter
`default_nettype wire

// ---- tb/tb_symbol_loop_filter_gain_ctrl.sv ----
// Self-checking bench for the symbol loop filter gains and lag accumulator load
`timescale 1ns/10ps
`default_nettype none
module tb_symbol_loop_filter_gain_ctrl;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic               core_clk    = 1'b0;          // Device clock
	logic               nrst        = 1'b0;          // Reset, low
	logic               wr_strobe   = 1'b0;          // Write pulse
	logic        [7:0]  wr_dest     = 8'h00;         // Destination
	logic        [31:0] wr_data     = 32'h00000000;  // Write word
	logic        [31:0] holding     = 32'h00000000;  // Holding bytes
	logic        [31:0] upper_limit = 32'h7FFFFFFF;  // Upper clamp
	logic        [31:0] lower_limit = 32'h80000000;  // Lower clamp
	logic               track_mode  = 1'b0;          // Gain set select
	logic signed [15:0] samp_err    = 16'sh0000;     // Sampling error
	logic               load_done_ff;                // Load status
	logic signed [31:0] nco_out_ff;                  // Filter output
	logic               out_valid_ff;                // Output strobe
	logic signed [39:0] lag_acc_ff;                  // Accumulator
	int                 failures    = 0;             // Mismatches
	int                 checks      = 0;             // Comparisons
	int                 seed        = 32'hBC6410A1;  // Random seed
	int                 cycles      = 0;             // Timeout count
	int                 gap         = 0;             // Clocks since strobe
	logic        [39:0] exp_q[$];                    // Expected accumulator
	logic signed [39:0] d0, d1, l0, l1;              // Lag steps, lead terms
	// ----------------------------------------
	// Clock and design
	// ----------------------------------------
	always #10 core_clk = ~core_clk;
	sym_loop_filter uut (.core_clk(core_clk), .nrst(nrst), .wr_strobe(wr_strobe),
		.wr_dest(wr_dest), .wr_data(wr_data), .holding(holding), .upper_limit(upper_limit),
		.lower_limit(lower_limit), .track_mode(track_mode), .samp_err(samp_err),
		.load_done_ff(load_done_ff), .nco_out_ff(nco_out_ff), .out_valid_ff(out_valid_ff),
		.lag_acc_ff(lag_acc_ff));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [39:0] e, input logic [39:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	function automatic bit near(input logic signed [39:0] a, input logic signed [39:0] b);
		return (a - b <= 2) && (b - a <= 2);
	endfunction
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One-cycle write on the falling edge
	task automatic wr(input logic [7:0] dest, input logic [31:0] data);
		@(negedge core_clk);
		wr_strobe = 1'b1;
		wr_dest = dest;
		wr_data = data;
		@(negedge core_clk);
		wr_strobe = 1'b0;
	endtask
	// Gain word, top byte random, reserved bits zero
	task automatic gain(input logic [7:0] d, input logic [3:0] fm, input logic [4:0] fe,
		input logic [3:0] gm, input logic [4:0] ge);
		wr(d, {8'($random(seed)), 6'h00, fm, fe, gm, ge});
	endtask
	// Load request, holding kept until completion
	task automatic load(input logic [31:0] h);
		int n;
		n = 0;
		holding = h;
		wr(sym_loop_pkg::DEST_LAG_INIT, $random(seed));
		check("done_low", 40'h0, {39'h0, load_done_ff});
		while (load_done_ff !== 1'b1 && n < 9)
		begin
			@(negedge core_clk);
			n++;
		end
		check("load_wait", 40'h1, {39'h0, n <= 8});
		if (samp_err == 16'sh0000)
			exp_q.push_back({h, 8'h00});
		repeat (10) @(negedge core_clk);
	endtask
	// Lead term at an output strobe, then lag step over one compute cycle
	task automatic measure(output logic signed [39:0] d, output logic signed [39:0] l);
		logic signed [39:0] a;
		// Step off a strobe left standing by the previous call
		@(negedge core_clk);
		while (out_valid_ff !== 1'b1)
		begin
			a = lag_acc_ff;
			@(negedge core_clk);
		end
		// Output pairs with the accumulator value from before the strobe
		l = nco_out_ff - $signed(a[39:8]);
		a = lag_acc_ff;
		repeat (8) @(negedge core_clk);
		d = lag_acc_ff - a;
	endtask
	// ----------------------------------------
	// Output watcher and timeout
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		#1;
		cycles++;
		if (out_valid_ff === 1'b1)
		begin
			if (gap != 0)
				check("valid_gap", 40'h8, 40'(gap));
			gap = 0;
			if (exp_q.size() > 0)
			begin
				check("lag_acc", exp_q[0], lag_acc_ff);
				check("nco_out", {8'h00, exp_q[0][39:8]}, 40'(unsigned'(nco_out_ff)));
				void'(exp_q.pop_front());
			end
		end
		if (gap != 0 || out_valid_ff === 1'b1)
			gap++;
		if (cycles == 5000)
		begin
			failures++;
			final_report();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(negedge core_clk);
		nrst = 1'b1;
		@(negedge core_clk);
		repeat (4) load($random(seed));
		d0 = lag_acc_ff;
		wr(8'h14, $random(seed));
		repeat (10) @(negedge core_clk);
		check("unmapped", d0, lag_acc_ff);
		$display("test load done");
		samp_err = 16'sh4000;
		gain(sym_loop_pkg::DEST_GAIN_ACQ, 4'h0, 5'h1E, 4'h0, 5'h0A);
		gain(sym_loop_pkg::DEST_GAIN_TRK, 4'h0, 5'h1D, 4'h0, 5'h09);
		load(32'h00000000);
		measure(d0, l0);
		track_mode = 1'b1;
		measure(d1, l1);
		check("lead_exp", 40'h1, {39'h0, near(l0, 2 * l1)});
		check("lag_small", d0, 2 * d1);
		track_mode = 1'b0;
		gain(sym_loop_pkg::DEST_GAIN_ACQ, 4'hF, 5'h1E, 4'h0, 5'h01);
		measure(d1, l1);
		check("lead_mant", 40'h1, {39'h0, near(16 * l1, 31 * l0)});
		gain(sym_loop_pkg::DEST_GAIN_ACQ, 4'h0, 5'h1E, 4'h0, 5'h14);
		measure(d0, l0);
		gain(sym_loop_pkg::DEST_GAIN_ACQ, 4'h0, 5'h1E, 4'hF, 5'h14);
		measure(d1, l1);
		check("lag_mant", 31 * d0, 16 * d1);
		gain(sym_loop_pkg::DEST_GAIN_ACQ, 4'h0, 5'h1E, 4'h0, 5'h13);
		measure(d1, l1);
		check("lag_exp", d0, 2 * d1);
		$display("test gains done");
		upper_limit = 32'h00000100;
		repeat (48) @(negedge core_clk);
		check("clamp_hi", {upper_limit, 8'h00}, lag_acc_ff);
		lower_limit = 32'hFFFFFF00;
		samp_err = -16'sh4000;
		repeat (64) @(negedge core_clk);
		check("clamp_lo", {lower_limit, 8'h00}, lag_acc_ff);
		$display("test limits done");
		final_report();
	end
endmodule // tb_symbol_loop_filter_gain_ctrl
`default_nettype wire
